/* design/counter_timer_irq_ctrl.sv */
// counter/timer, interrupt arbitration and reset/initialization control
// assumes op strobes come from same-clock decode logic, one cycle each;
// flag, interrupt, clear and wait pins are asynchronous
//
// Overview of operation
// R1: external request level, counter request latched
// R2: latch sets on underflow and gate rise
// R3: service needs source enable and master enable
// R4: reset sets enables; ops set/clear each
// R5: branches follow pending requests, ignoring enables
// R6: latch clears on branch, reset, stopped load
// R7: 8-bit down-counter reloads after 01
// R8: load writes both when stopped, else holding
// R9: event modes count flag falling edges
// R10: timer counts every 32 timing pulses
// R11: prescaler reset outside timer, reset, stop
// R12: pulse-width one counts while flag low
// R13: pulse-width two gated by flag two
// R14: mode change keeps count, flags stay testable
// R15: stop op clears mode, halts counting
// R16: decrement op counts under software
// R17: toggle enable flips output on underflow
// R18: toggle enable cleared by stopped load, reset, branch
// R19: clear and wait select reset/pause/run
// R20: reset forces defined output levels
// R21: reset clears latch, stops counter, modes
// R22: nine-clock init cycle after reset
// R23: interrupt saves selectors, sets 2 and 1
// R24: return ops restore selectors, set/clear master
// R25: pins synchronized and edge detected
`timescale 1ns/100ps
`default_nettype none
module counter_timer_irq_ctrl
(
	input  wire logic                         CLK_SYS,
	input  wire logic                         RST_B,
	input  wire logic                         CLEAR_B,
	input  wire logic                         WAIT_B,
	input  wire logic                         FLAG_INPUT_ONE,
	input  wire logic                         FLAG_INPUT_TWO,
	input  wire logic                         EXT_IRQ,
	input  wire logic                         DMA_REQ,
	input  wire logic [7:0]                   ACCUM,
	input  wire logic                         LOAD_COUNTER_OP,
	input  wire logic                         STOP_COUNTER_OP,
	input  wire logic                         DECREMENT_COUNTER_OP,
	input  wire logic                         SET_MODE_OP,
	input  wire counter_timer_pkg::ctr_mode_t MODE_SEL,
	input  wire logic                         TOGGLE_ON_UNDERFLOW_OP,
	input  wire logic                         SET_OUTPUT_FLOP_OP,
	input  wire logic                         RESET_OUTPUT_FLOP_OP,
	input  wire logic                         COUNTER_IRQ_ENABLE_OP,
	input  wire logic                         COUNTER_IRQ_DISABLE_OP,
	input  wire logic                         EXTERNAL_IRQ_ENABLE_OP,
	input  wire logic                         EXTERNAL_IRQ_DISABLE_OP,
	input  wire logic                         RETURN_ENABLE_OP,
	input  wire logic                         RETURN_DISABLE_OP,
	input  wire logic                         BRANCH_ON_COUNTER_IRQ,
	input  wire logic                         BRANCH_ON_EXTERNAL_IRQ,
	input  wire logic                         MEM_WRITE_REQ,
	input  wire logic [7:0]                   CPU_ADDR,
	input  wire logic [7:0]                   CPU_DATA,
	input  wire logic [2:0]                   IO_CMD_IN,
	output logic                              BRANCH_TAKEN,
	output logic                              IRQ_ACCEPT,
	output logic [7:0]                        COUNT,
	output logic [7:0]                        COUNTER_HOLDING_REGISTER,
	output logic                              COUNTER_IRQ_PENDING,
	output logic                              MASTER_IRQ_ENABLE,
	output logic                              COUNTER_IRQ_ENABLE,
	output logic                              EXTERNAL_IRQ_ENABLE,
	output logic                              TOGGLE_ON_UNDERFLOW_ENABLE,
	output logic                              OUTPUT_FLOP,
	output logic [1:0]                        STATE_CODE_LINES,
	output logic [3:0]                        SEL_X,
	output logic [3:0]                        SEL_P,
	output logic [7:0]                        SAVED_CONTEXT,
	output logic                              INIT_CYCLE,
	output logic                              TIMING_PULSE_ONE,
	output logic                              TIMING_PULSE_TWO,
	output logic                              MEMORY_READ_STROBE_B,
	output logic                              MEMORY_WRITE_STROBE_B,
	output logic [2:0]                        IO_COMMAND_LINES,
	output logic [7:0]                        MEMORY_ADDRESS_LINES,
	output logic [7:0]                        DATA_BUS_OUT
);
	import counter_timer_pkg::*;

	logic [4:0]  pins;
	logic [4:0]  sync1_r;
	logic [4:0]  sync2_r;
	logic [4:0]  prev_r;
	logic        f1;
	logic        f2;
	logic        f1_fall;
	logic        f2_fall;
	logic        f1_rise;
	logic        f2_rise;
	logic        ext_s;
	logic        pin_rst;
	logic        run;
	cyc_t        cyc_r;
	cyc_t        cyc_nxt;
	logic [3:0]  step_r;
	logic        end_cyc;
	logic        tpa_evt;
	logic        tpa_r;
	logic        tpb_r;
	logic        irq_req;
	logic        irq_take;
	logic        irq_ack_r;
	ctr_mode_t   mode_r;
	logic [4:0]  presc_r;
	logic [7:0]  cnt_r;
	logic [7:0]  hold_r;
	logic        stopped;
	logic        load_stop;
	logic        dec_evt;
	logic        underflow;
	logic        pw_end;
	logic        cil_r;
	logic        cil_set;
	logic        cil_clr;
	logic        etq_r;
	logic        q_r;
	logic        mie_r;
	logic        cie_r;
	logic        xie_r;
	logic [3:0]  x_r;
	logic [3:0]  p_r;
	logic [7:0]  t_r;
	logic [1:0]  sc_r;
	logic        rd_b_r;
	logic        wr_b_r;
	logic [2:0]  io_r;
	logic [7:0]  addr_r;
	logic [7:0]  data_r;

	// pins pass two flops; prev_r only looks at the second stage
	assign pins = {WAIT_B, CLEAR_B, EXT_IRQ, FLAG_INPUT_TWO, FLAG_INPUT_ONE};

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			sync1_r <= PINS_RST;
			sync2_r <= PINS_RST;
			prev_r  <= PINS_RST;
		end
		else
		begin
			sync1_r <= pins; // R25
			sync2_r <= sync1_r; // R25
			prev_r  <= sync2_r; // R25
		end
	end

	assign f1      = sync2_r[0];
	assign f2      = sync2_r[1];
	assign ext_s   = sync2_r[2]; // R1
	assign f1_fall = prev_r[0] & ~f1; // R25
	assign f2_fall = prev_r[1] & ~f2; // R25
	assign f1_rise = ~prev_r[0] & f1; // R25
	assign f2_rise = ~prev_r[1] & f2; // R25
	// both low is illegal; treated as reset so the block stays safe
	assign pin_rst = ~sync2_r[3]; // R19
	assign run     = sync2_r[3] & sync2_r[4]; // R19

	// machine cycle timing; pause freezes step and timing pulses
	assign end_cyc = run && (step_r == ((cyc_r == CY_INIT) ? INIT_LAST : CYC_LAST));
	assign tpa_evt = run && (step_r == TPA_STEP);

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			step_r <= 4'h0;
		else if (pin_rst)
			step_r <= 4'h0;
		else if (end_cyc)
			step_r <= 4'h0;
		else if (run)
			step_r <= step_r + 4'h1;
	end

	always_comb
	begin
		cyc_nxt = cyc_r;
		case (cyc_r)
			CY_INIT:  cyc_nxt = DMA_REQ ? CY_DMA : CY_FETCH; // R22
			CY_FETCH: cyc_nxt = CY_EXEC;
			CY_EXEC:  cyc_nxt = DMA_REQ ? CY_DMA : (irq_req ? CY_INT : CY_FETCH);
			CY_DMA:   cyc_nxt = CY_FETCH;
			CY_INT:   cyc_nxt = CY_FETCH;
			default:  cyc_nxt = CY_FETCH;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			cyc_r <= CY_INIT;
		else if (pin_rst)
			cyc_r <= CY_INIT; // R22
		else if (end_cyc)
			cyc_r <= cyc_nxt;
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			tpa_r <= 1'b0;
			tpb_r <= 1'b0;
		end
		else if (pin_rst)
		begin
			tpa_r <= 1'b0; // R20
			tpb_r <= 1'b0; // R20
		end
		else if (run)
		begin
			tpa_r <= (step_r == TPA_STEP);
			tpb_r <= (step_r == TPB_STEP);
		end
	end

	// interrupt arbitration; init cycle suppresses service
	assign irq_req  = mie_r & ((xie_r & ext_s) | (cie_r & cil_r)) & (cyc_r != CY_INIT); // R3 R22
	// dma wins over an interrupt at the same cycle boundary
	assign irq_take = end_cyc & (cyc_r == CY_EXEC) & ~DMA_REQ & irq_req; // R23
	assign BRANCH_TAKEN = (BRANCH_ON_COUNTER_IRQ & cil_r) | (BRANCH_ON_EXTERNAL_IRQ & ext_s); // R5

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			irq_ack_r <= 1'b0;
		else
			irq_ack_r <= irq_take & ~pin_rst;
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			mie_r <= 1'b1;
		else if (pin_rst)
			mie_r <= 1'b1; // R4
		else if (cyc_r == CY_INIT)
			mie_r <= 1'b1; // R22
		else if (irq_take)
			mie_r <= 1'b0; // R23
		else if (RETURN_ENABLE_OP)
			mie_r <= 1'b1; // R24
		else if (RETURN_DISABLE_OP)
			mie_r <= 1'b0; // R24
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			cie_r <= 1'b1;
			xie_r <= 1'b1;
		end
		else if (pin_rst)
		begin
			cie_r <= 1'b1; // R4 R21
			xie_r <= 1'b1; // R4 R21
		end
		else
		begin
			if (COUNTER_IRQ_ENABLE_OP)
				cie_r <= 1'b1; // R4
			else if (COUNTER_IRQ_DISABLE_OP)
				cie_r <= 1'b0; // R4
			if (EXTERNAL_IRQ_ENABLE_OP)
				xie_r <= 1'b1; // R4
			else if (EXTERNAL_IRQ_DISABLE_OP)
				xie_r <= 1'b0; // R4
		end
	end

	// selectors survive a pin reset so init can save the old pair
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			x_r <= 4'h0;
			p_r <= 4'h0;
			t_r <= 8'h00;
		end
		else if (pin_rst)
		begin
			x_r <= x_r;
		end
		else if (cyc_r == CY_INIT && step_r == 4'h0 && run)
		begin
			t_r <= {x_r, p_r}; // R22
			x_r <= 4'h0; // R22
			p_r <= 4'h0; // R22
		end
		else if (irq_take)
		begin
			t_r <= {x_r, p_r}; // R23
			x_r <= IRQ_SEL_X; // R23
			p_r <= IRQ_SEL_P; // R23
		end
		else if (RETURN_ENABLE_OP || RETURN_DISABLE_OP)
		begin
			x_r <= t_r[7:4]; // R24
			p_r <= t_r[3:0]; // R24
		end
	end

	// counter core
	assign stopped   = (mode_r == MD_STOP);
	assign load_stop = LOAD_COUNTER_OP & stopped;
	assign pw_end    = ((mode_r == MD_PW1) & f1_rise) | ((mode_r == MD_PW2) & f2_rise); // R12 R13
	always_comb
	begin
		dec_evt = DECREMENT_COUNTER_OP; // R16
		case (mode_r)
			MD_EV1:   dec_evt = dec_evt | f1_fall; // R9
			MD_EV2:   dec_evt = dec_evt | f2_fall; // R9
			MD_TIMER: dec_evt = dec_evt | (tpa_evt & (presc_r == 5'h00)); // R10
			MD_PW1:   dec_evt = dec_evt | (tpa_evt & ~f1); // R12
			MD_PW2:   dec_evt = dec_evt | (tpa_evt & ~f2); // R13
			default:  dec_evt = dec_evt;
		endcase
	end
	assign underflow = dec_evt & ~load_stop & (cnt_r == UNDERFLOW_AT); // R7

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			mode_r <= MD_STOP;
		else if (pin_rst)
			mode_r <= MD_STOP; // R21
		else if (STOP_COUNTER_OP)
			mode_r <= MD_STOP; // R15
		else if (pw_end)
			mode_r <= MD_STOP; // R12 R13
		else if (SET_MODE_OP)
			mode_r <= MODE_SEL; // R14
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			presc_r <= PRESC_INIT;
		else if (pin_rst || mode_r != MD_TIMER || STOP_COUNTER_OP)
			presc_r <= PRESC_INIT; // R11
		else if (tpa_evt)
			presc_r <= (presc_r == 5'h00) ? PRESC_INIT : presc_r - 5'h01; // R10
	end

	// count is held through a clear-pin reset and mode changes; RST_B clears it, stopped loads and counting change it
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			cnt_r  <= 8'h00;
			hold_r <= 8'h00;
		end
		else if (pin_rst)
		begin
			cnt_r <= cnt_r;
		end
		else
		begin
			if (LOAD_COUNTER_OP)
				hold_r <= ACCUM; // R8
			if (load_stop)
				cnt_r <= ACCUM; // R8
			else if (underflow)
				cnt_r <= hold_r; // R7
			else if (dec_evt)
				cnt_r <= cnt_r - 8'h01; // R7
		end
	end

	// a new event wins over a clear in the same cycle
	assign cil_set = underflow | pw_end; // R2
	assign cil_clr = (BRANCH_ON_COUNTER_IRQ & cil_r) | load_stop; // R6

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			cil_r <= 1'b0;
		else if (pin_rst)
			cil_r <= 1'b0; // R6 R21
		else if (cil_set)
			cil_r <= 1'b1; // R1 R2
		else if (cil_clr)
			cil_r <= 1'b0; // R6
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			etq_r <= 1'b0;
		else if (pin_rst)
			etq_r <= 1'b0; // R18 R21
		else if (TOGGLE_ON_UNDERFLOW_OP)
			etq_r <= 1'b1; // R17
		else if (load_stop || (BRANCH_ON_COUNTER_IRQ && cil_r))
			etq_r <= 1'b0; // R18
	end

	// explicit set/reset ops override a toggle in the same cycle
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			q_r <= 1'b0;
		else if (pin_rst)
			q_r <= 1'b0; // R20
		else if (SET_OUTPUT_FLOP_OP)
			q_r <= 1'b1; // R17
		else if (RESET_OUTPUT_FLOP_OP)
			q_r <= 1'b0; // R17
		else if (etq_r && underflow)
			q_r <= ~q_r; // R17
	end

	// bus-side outputs
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			sc_r   <= SC_EXEC;
			rd_b_r <= 1'b1;
			wr_b_r <= 1'b1;
			io_r   <= 3'h0;
			addr_r <= 8'h00;
			data_r <= 8'h00;
		end
		else if (pin_rst || cyc_r == CY_INIT)
		begin
			sc_r   <= SC_EXEC; // R20 R22
			rd_b_r <= 1'b1; // R20
			wr_b_r <= 1'b1; // R20
			io_r   <= 3'h0; // R20
			addr_r <= 8'h00; // R20 R22
			data_r <= 8'h00; // R20
		end
		else if (run)
		begin
			case (cyc_r)
				CY_FETCH: sc_r <= SC_FETCH;
				CY_DMA:   sc_r <= SC_DMA;
				CY_INT:   sc_r <= SC_INT;
				default:  sc_r <= SC_EXEC;
			endcase
			rd_b_r <= ~(cyc_r == CY_FETCH && step_r >= RD_FIRST && step_r <= RD_LAST);
			wr_b_r <= ~(cyc_r == CY_EXEC && MEM_WRITE_REQ && step_r >= WR_FIRST && step_r <= TPB_STEP);
			io_r   <= (cyc_r == CY_EXEC) ? IO_CMD_IN : 3'h0;
			addr_r <= CPU_ADDR;
			data_r <= MEM_WRITE_REQ ? CPU_DATA : 8'h00;
		end
	end

	assign IRQ_ACCEPT                 = irq_ack_r;
	assign COUNT                      = cnt_r;
	assign COUNTER_HOLDING_REGISTER   = hold_r;
	assign COUNTER_IRQ_PENDING        = cil_r;
	assign MASTER_IRQ_ENABLE          = mie_r;
	assign COUNTER_IRQ_ENABLE         = cie_r;
	assign EXTERNAL_IRQ_ENABLE        = xie_r;
	assign TOGGLE_ON_UNDERFLOW_ENABLE = etq_r;
	assign OUTPUT_FLOP                = q_r;
	assign STATE_CODE_LINES           = sc_r;
	assign SEL_X                      = x_r;
	assign SEL_P                      = p_r;
	assign SAVED_CONTEXT              = t_r;
	assign INIT_CYCLE                 = (cyc_r == CY_INIT);
	assign TIMING_PULSE_ONE           = tpa_r;
	assign TIMING_PULSE_TWO           = tpb_r;
	assign MEMORY_READ_STROBE_B       = rd_b_r;
	assign MEMORY_WRITE_STROBE_B      = wr_b_r;
	assign IO_COMMAND_LINES           = io_r;
	assign MEMORY_ADDRESS_LINES       = addr_r;
	assign DATA_BUS_OUT               = data_r;

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);

	reload_at_one_a: assert property (underflow && !pin_rst |=> cnt_r == $past(hold_r) && cil_r) // R7
		else $error("no reload or latch after count 01");
	load_stopped_a: assert property (load_stop && !pin_rst && !TOGGLE_ON_UNDERFLOW_OP
		|=> cnt_r == $past(ACCUM) && hold_r == $past(ACCUM) && !cil_r && !etq_r) // R8
		else $error("stopped load did not load both or clear latch");
	load_running_a: assert property (LOAD_COUNTER_OP && !stopped && !pin_rst && !BRANCH_ON_COUNTER_IRQ
		|=> hold_r == $past(ACCUM) && (cil_r || !$past(cil_r))) // R8
		else $error("running load wrong");
	presc_hold_a: assert property (mode_r != MD_TIMER |=> presc_r == PRESC_INIT) // R11
		else $error("prescaler not held outside timer mode");
	timer_div_a: assert property (mode_r == MD_TIMER && tpa_evt && presc_r == 5'h00 && !load_stop
		&& cnt_r != UNDERFLOW_AT && !pin_rst |=> cnt_r == $past(cnt_r) - 8'h01) // R10
		else $error("timer did not decrement on prescaler wrap");
	pw_stop_a: assert property (mode_r == MD_PW1 && f1_rise && !pin_rst |=> mode_r == MD_STOP && cil_r) // R12
		else $error("pulse width end not handled");
	irq_entry_a: assert property (irq_take && !pin_rst
		|=> !mie_r && x_r == IRQ_SEL_X && p_r == IRQ_SEL_P && IRQ_ACCEPT && t_r == $past({x_r, p_r})) // R23
		else $error("interrupt entry state wrong");
	init_exit_a: assert property (cyc_r == CY_INIT && end_cyc && !pin_rst
		|=> (cyc_r == CY_FETCH || cyc_r == CY_DMA) && mie_r && $past(step_r) == INIT_LAST) // R22
		else $error("init cycle length or exit wrong");
	branch_clear_a: assert property (BRANCH_ON_COUNTER_IRQ && cil_r && !cil_set && !pin_rst
		|-> BRANCH_TAKEN ##1 !cil_r) // R5 R6
		else $error("counter branch did not clear latch");
	toggle_q_a: assert property (etq_r && underflow && !SET_OUTPUT_FLOP_OP && !RESET_OUTPUT_FLOP_OP && !pin_rst
		|=> OUTPUT_FLOP != $past(q_r)) // R17
		else $error("output flop did not toggle on underflow");
endmodule
`default_nettype wire

/* design/counter_timer_pkg.sv */
// constants and types for the counter/timer and interrupt control block
// assumes a single system clock; cycle and init lengths are in system clocks, the prescale in timing pulses
`default_nettype none
package counter_timer_pkg;
	localparam int          CYCLE_CLKS   = 8;
	localparam int          INIT_CLKS    = 9;
	localparam int          PRESCALE_DIV = 32;
	localparam logic [3:0]  CYC_LAST     = 4'(CYCLE_CLKS - 1);
	localparam logic [3:0]  INIT_LAST    = 4'(INIT_CLKS - 1);
	localparam logic [3:0]  TPA_STEP     = 4'h1;
	localparam logic [3:0]  TPB_STEP     = 4'h6;
	localparam logic [3:0]  RD_FIRST     = 4'h2;
	localparam logic [3:0]  RD_LAST      = 4'h6;
	localparam logic [3:0]  WR_FIRST     = 4'h5;
	localparam logic [4:0]  PRESC_INIT   = 5'(PRESCALE_DIV - 1);
	localparam logic [7:0]  UNDERFLOW_AT = 8'h01;
	localparam logic [3:0]  IRQ_SEL_X    = 4'h2;
	localparam logic [3:0]  IRQ_SEL_P    = 4'h1;
	localparam logic [1:0]  SC_FETCH     = 2'h0;
	localparam logic [1:0]  SC_EXEC      = 2'h1;
	localparam logic [1:0]  SC_DMA       = 2'h2;
	localparam logic [1:0]  SC_INT       = 2'h3;
	localparam logic [4:0]  PINS_RST     = 5'h00;
	typedef enum logic [2:0] {MD_STOP, MD_EV1, MD_EV2, MD_TIMER, MD_PW1, MD_PW2} ctr_mode_t;
	typedef enum logic [2:0] {CY_INIT, CY_FETCH, CY_EXEC, CY_DMA, CY_INT} cyc_t;
endpackage
`default_nettype wire

/* testbench/flag_pulse_source.sv */
// far-side model: flag pins, external request level, clear and wait pins
// assumes its tasks are called from one bench process clocked by CLK_SYS
`timescale 1ns/100ps
`default_nettype none
module flag_pulse_source
(
	input  wire logic CLK_SYS,
	output logic      FLAG_ONE,
	output logic      FLAG_TWO,
	output logic      EXT_REQ,
	output logic      CLEAR_B,
	output logic      WAIT_B
);
	initial
	begin
		FLAG_ONE = 1'b1;
		FLAG_TWO = 1'b1;
		EXT_REQ = 1'b0;
		CLEAR_B = 1'b1;
		WAIT_B = 1'b1;
	end

	// low pulse on one flag pin; the tail lets the synchronizer see the rise
	task automatic pulse_flag(input int which, input int low_clks);
		@(posedge CLK_SYS);
		FLAG_ONE <= (which != 0);
		FLAG_TWO <= (which == 0);
		repeat (low_clks) @(posedge CLK_SYS);
		FLAG_ONE <= 1'b1;
		FLAG_TWO <= 1'b1;
		repeat (5) @(posedge CLK_SYS);
	endtask

	// request level is not latched by the block, so it is held here
	task automatic set_ext(input logic lvl);
		@(posedge CLK_SYS);
		EXT_REQ <= lvl;
	endtask

	// wait is forced high while clear is low: both low is never driven
	task automatic set_ctrl(input logic clr_b, input logic wt_b);
		@(posedge CLK_SYS);
		CLEAR_B <= clr_b;
		WAIT_B <= wt_b | ~clr_b;
	endtask
endmodule
`default_nettype wire

/* testbench/test_counter_timer_irq_ctrl.sv */
// bench for the counter/timer and interrupt control block
// assumes flag_pulse_source drives the pins; bus inputs are held idle except dma_req, raised for the last init check
`timescale 1ns/100ps
`default_nettype none
module test_counter_timer_irq_ctrl;
	import counter_timer_pkg::*;
	localparam int op_load = 0;
	localparam int op_stop = 1;
	localparam int op_dec = 2;
	localparam int op_mode = 3;
	localparam int op_tog = 4;
	localparam int op_setq = 5;
	localparam int op_rstq = 6;
	localparam int op_ret_en = 11;
	localparam int op_ret_dis = 12;
	localparam int op_br_c = 13;
	localparam int op_br_x = 14;
	localparam logic [7:0] en_exp [4] = '{8'h03, 8'h01, 8'h01, 8'h00};
	logic        CLK_SYS = 1'b0;
	logic        RST_B = 1'b0;
	logic [14:0] op = '0;
	logic [7:0]  accum = 8'h00;
	logic        dma_req = 1'b0;
	logic        mem_wr = 1'b0;
	logic [2:0]  io_cmd = 3'h0;
	ctr_mode_t   mode_sel = MD_STOP;
	logic        flag_one, flag_two, ext_req, clear_b, wait_b;
	logic        BRANCH_TAKEN, IRQ_ACCEPT, COUNTER_IRQ_PENDING, MASTER_IRQ_ENABLE, COUNTER_IRQ_ENABLE;
	logic        EXTERNAL_IRQ_ENABLE, TOGGLE_ON_UNDERFLOW_ENABLE, OUTPUT_FLOP, INIT_CYCLE;
	logic        TIMING_PULSE_ONE, TIMING_PULSE_TWO, MEMORY_READ_STROBE_B, MEMORY_WRITE_STROBE_B;
	logic [7:0]  COUNT, COUNTER_HOLDING_REGISTER, SAVED_CONTEXT, MEMORY_ADDRESS_LINES, DATA_BUS_OUT, m;
	logic [3:0]  SEL_X, SEL_P;
	logic [1:0]  STATE_CODE_LINES;
	logic [2:0]  IO_COMMAND_LINES;
	int          failures = 0;
	int          comparisons = 0;
	int          n;

	always #4 CLK_SYS = ~CLK_SYS;

	flag_pulse_source src (.CLK_SYS(CLK_SYS), .FLAG_ONE(flag_one), .FLAG_TWO(flag_two), .EXT_REQ(ext_req),
		.CLEAR_B(clear_b), .WAIT_B(wait_b));

	counter_timer_irq_ctrl dut (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .CLEAR_B(clear_b), .WAIT_B(wait_b),
		.FLAG_INPUT_ONE(flag_one), .FLAG_INPUT_TWO(flag_two), .EXT_IRQ(ext_req), .DMA_REQ(dma_req),
		.ACCUM(accum), .LOAD_COUNTER_OP(op[0]), .STOP_COUNTER_OP(op[1]), .DECREMENT_COUNTER_OP(op[2]),
		.SET_MODE_OP(op[3]), .MODE_SEL(mode_sel), .TOGGLE_ON_UNDERFLOW_OP(op[4]), .SET_OUTPUT_FLOP_OP(op[5]),
		.RESET_OUTPUT_FLOP_OP(op[6]), .COUNTER_IRQ_ENABLE_OP(op[7]), .COUNTER_IRQ_DISABLE_OP(op[8]),
		.EXTERNAL_IRQ_ENABLE_OP(op[9]), .EXTERNAL_IRQ_DISABLE_OP(op[10]), .RETURN_ENABLE_OP(op[11]),
		.RETURN_DISABLE_OP(op[12]), .BRANCH_ON_COUNTER_IRQ(op[13]), .BRANCH_ON_EXTERNAL_IRQ(op[14]),
		.MEM_WRITE_REQ(mem_wr), .CPU_ADDR(8'h00), .CPU_DATA(8'h00), .IO_CMD_IN(io_cmd),
		.BRANCH_TAKEN(BRANCH_TAKEN), .IRQ_ACCEPT(IRQ_ACCEPT), .COUNT(COUNT),
		.COUNTER_HOLDING_REGISTER(COUNTER_HOLDING_REGISTER), .COUNTER_IRQ_PENDING(COUNTER_IRQ_PENDING),
		.MASTER_IRQ_ENABLE(MASTER_IRQ_ENABLE), .COUNTER_IRQ_ENABLE(COUNTER_IRQ_ENABLE),
		.EXTERNAL_IRQ_ENABLE(EXTERNAL_IRQ_ENABLE), .TOGGLE_ON_UNDERFLOW_ENABLE(TOGGLE_ON_UNDERFLOW_ENABLE),
		.OUTPUT_FLOP(OUTPUT_FLOP), .STATE_CODE_LINES(STATE_CODE_LINES), .SEL_X(SEL_X), .SEL_P(SEL_P),
		.SAVED_CONTEXT(SAVED_CONTEXT), .INIT_CYCLE(INIT_CYCLE), .TIMING_PULSE_ONE(TIMING_PULSE_ONE),
		.TIMING_PULSE_TWO(TIMING_PULSE_TWO), .MEMORY_READ_STROBE_B(MEMORY_READ_STROBE_B),
		.MEMORY_WRITE_STROBE_B(MEMORY_WRITE_STROBE_B), .IO_COMMAND_LINES(IO_COMMAND_LINES),
		.MEMORY_ADDRESS_LINES(MEMORY_ADDRESS_LINES), .DATA_BUS_OUT(DATA_BUS_OUT));

	task automatic test_done;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one-cycle op strobe; the value doubles as accumulator and mode code
	task automatic issue(input int i, input logic [7:0] v);
		@(posedge CLK_SYS);
		accum <= v;
		mode_sel <= ctr_mode_t'(v[2:0]);
		op[i] <= 1'b1;
		@(posedge CLK_SYS);
		op[i] <= 1'b0;
		#1;
	endtask

	// branch answer is combinational, so it is looked at inside the op cycle
	task automatic branch(input int i, input logic [7:0] exp);
		@(posedge CLK_SYS);
		op[i] <= 1'b1;
		#1;
		check({7'h0, BRANCH_TAKEN}, exp);
		@(posedge CLK_SYS);
		op[i] <= 1'b0;
		#1;
	endtask

	// sel 0 waits for an accepted interrupt, sel 1 for the init cycle
	task automatic need(input int sel, input int lim);
		int k;
		k = 0;
		while ((sel == 0 ? IRQ_ACCEPT : INIT_CYCLE) !== 1'b1 && k < lim)
		begin
			@(posedge CLK_SYS);
			#1;
			k++;
		end
		if (k >= lim)
		begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, 8'h00, 8'h01);
			test_done();
		end
	endtask

	task automatic init_chk(input logic [1:0] sc);
		int k;
		need(1, 30);
		// the clear pin needs two sync edges before the init steps start
		repeat (2) @(posedge CLK_SYS);
		k = 0;
		while (INIT_CYCLE === 1'b1 && k < 20)
		begin
			@(posedge CLK_SYS);
			#1;
			k++;
		end
		check(8'(k), 8'h09);
		check({7'h0, MASTER_IRQ_ENABLE}, 8'h01);
		check({SEL_X, SEL_P}, 8'h00);
		@(posedge CLK_SYS);
		#1;
		check({6'h0, STATE_CODE_LINES}, {6'h0, sc});
	endtask

	initial
	begin
		#400000;
		failures++;
		$display("unexpected at %0t: got %h expected %h", $time, 8'h00, 8'h01);
		test_done();
	end

	initial
	begin
		repeat (10) @(posedge CLK_SYS);
		#1;
		check({1'b0, OUTPUT_FLOP, STATE_CODE_LINES, TIMING_PULSE_ONE, TIMING_PULSE_TWO, MEMORY_READ_STROBE_B,
			MEMORY_WRITE_STROBE_B}, 8'h13);
		check(MEMORY_ADDRESS_LINES | DATA_BUS_OUT | {5'h0, IO_COMMAND_LINES}, 8'h00);
		check({3'h0, MASTER_IRQ_ENABLE, COUNTER_IRQ_ENABLE, EXTERNAL_IRQ_ENABLE, COUNTER_IRQ_PENDING,
			TOGGLE_ON_UNDERFLOW_ENABLE}, 8'h1C);
		@(posedge CLK_SYS);
		RST_B <= 1'b1;
		init_chk(SC_FETCH);
		$display("test reset_init done");
		issue(op_load, 8'h03);
		check(COUNT & COUNTER_HOLDING_REGISTER, 8'h03);
		issue(op_setq, 8'h00);
		check({7'h0, OUTPUT_FLOP}, 8'h01);
		issue(op_rstq, 8'h00);
		check({7'h0, OUTPUT_FLOP}, 8'h00);
		issue(op_tog, 8'h00);
		issue(op_dec, 8'h00);
		issue(op_dec, 8'h00);
		check(COUNT, 8'h01);
		issue(op_dec, 8'h00);
		check(COUNT, 8'h03);
		check({6'h0, COUNTER_IRQ_PENDING, OUTPUT_FLOP}, 8'h03);
		$display("test software_count done");
		need(0, 40);
		check({SEL_X, SEL_P}, 8'h21);
		check({7'h0, MASTER_IRQ_ENABLE}, 8'h00);
		check(SAVED_CONTEXT, 8'h00);
		issue(op_mode, {5'h0, MD_EV1});
		issue(op_load, 8'h05);
		check(COUNTER_HOLDING_REGISTER, 8'h05);
		check({COUNT[6:0], COUNTER_IRQ_PENDING}, 8'h07);
		issue(op_ret_en, 8'h00);
		check({3'h0, MASTER_IRQ_ENABLE, SEL_X}, 8'h10);
		need(0, 40);
		branch(op_br_c, 8'h01);
		check({6'h0, COUNTER_IRQ_PENDING, TOGGLE_ON_UNDERFLOW_ENABLE}, 8'h00);
		issue(op_ret_dis, 8'h00);
		check({3'h0, MASTER_IRQ_ENABLE, SEL_P}, 8'h00);
		$display("test interrupt_service done");
		src.pulse_flag(0, 6);
		src.pulse_flag(0, 6);
		check(COUNT, 8'h01);
		src.pulse_flag(1, 6);
		check(COUNT, 8'h01);
		src.pulse_flag(0, 6);
		check(COUNT, 8'h05);
		check({7'h0, COUNTER_IRQ_PENDING}, 8'h01);
		issue(op_stop, 8'h00);
		src.pulse_flag(0, 6);
		check(COUNT, 8'h05);
		$display("test event_count done");
		branch(op_br_x, 8'h00);
		src.set_ext(1'b1);
		repeat (4) @(posedge CLK_SYS);
		branch(op_br_x, 8'h01);
		for (int k = 7; k < 11; k++)
		begin
			issue(k, 8'h00);
			check({6'h0, COUNTER_IRQ_ENABLE, EXTERNAL_IRQ_ENABLE}, en_exp[k - 7]);
		end
		issue(op_ret_en, 8'h00);
		n = 0;
		repeat (40)
		begin
			@(posedge CLK_SYS);
			#1;
			n = n + int'(IRQ_ACCEPT === 1'b1);
		end
		check(8'(n), 8'h00);
		issue(9, 8'h00);
		need(0, 40);
		src.set_ext(1'b0);
		issue(op_ret_dis, 8'h00);
		repeat (4) @(posedge CLK_SYS);
		branch(op_br_x, 8'h00);
		$display("test external_request done");
		issue(op_load, 8'h02);
		check({7'h0, COUNTER_IRQ_PENDING}, 8'h00);
		issue(op_mode, {5'h0, MD_TIMER});
		n = 0;
		while (COUNT === 8'h02 && n < 400)
		begin
			@(posedge CLK_SYS);
			#1;
			n++;
		end
		check({7'h0, n >= 244 && n <= 268}, 8'h01);
		issue(op_stop, 8'h00);
		$display("test timer done");
		for (int k = 0; k < 2; k++)
		begin
			issue(op_load, 8'h10);
			issue(op_mode, {5'h0, k == 0 ? MD_PW1 : MD_PW2});
			src.pulse_flag(k, 40);
			check({7'h0, COUNTER_IRQ_PENDING}, 8'h01);
			check({7'h0, COUNT >= 8'h0A && COUNT <= 8'h0C}, 8'h01);
			m = COUNT;
			repeat (24) @(posedge CLK_SYS);
			#1;
			check(COUNT, m);
		end
		$display("test pulse_width done");
		src.set_ctrl(1'b1, 1'b0);
		repeat (3) @(posedge CLK_SYS);
		#1;
		m = {7'h0, TIMING_PULSE_ONE};
		n = 0;
		repeat (24)
		begin
			@(posedge CLK_SYS);
			#1;
			n = n + int'(TIMING_PULSE_ONE !== m[0]);
		end
		check(8'(n), 8'h00);
		src.set_ctrl(1'b1, 1'b1);
		src.set_ctrl(1'b0, 1'b1);
		repeat (4) @(posedge CLK_SYS);
		#1;
		check({4'h0, COUNTER_IRQ_ENABLE, EXTERNAL_IRQ_ENABLE, STATE_CODE_LINES}, 8'h0D);
		@(posedge CLK_SYS);
		dma_req <= 1'b1;
		src.set_ctrl(1'b1, 1'b1);
		init_chk(SC_DMA);
		$display("test control_modes done");
		test_done();
	end
endmodule
`default_nettype wire
